// file: verilog/dpt_map.svh
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DPT_OFS_CTRL 8'h00
`define DPT_OFS_T0_HIGH 8'h04
`define DPT_OFS_T0_LOW 8'h08
`define DPT_OFS_T0_RELOAD 8'h0C
`define DPT_OFS_T2_PERIOD 8'h10
`define DPT_OFS_T2_DUTY0 8'h14
`define DPT_OFS_IRQ_STAT 8'h20
`define DPT_OFS_IRQ_MASK 8'h24
`define DPT_OFS_STATUS 8'h28
// ****************************************
// Control field positions
// ****************************************
`define DPT_CTRL_T0_EN 0
`define DPT_CTRL_T0_SEL_LO 1
`define DPT_CTRL_T0_SEL_HI 3
`define DPT_CTRL_T2_EN 4
`define DPT_CTRL_T2_SLOW 5
`define DPT_CTRL_T2_DIV_LO 6
`define DPT_CTRL_T2_DIV_HI 7
`define DPT_CTRL_W 8
// ****************************************
// Interrupt bit positions and reset values
// ****************************************
`define DPT_IRQ_T0_TICK 0
`define DPT_IRQ_T0_WRAP 1
`define DPT_IRQ_T2_WRAP 2
`define DPT_IRQ_W 3
`define DPT_RST_CTRL 8'h00
`define DPT_RST_T0 16'h0000
`define DPT_RST_T2 14'h0000
`define DPT_T2_MIN_PERIOD 14'h0002
`define DPT_T0_SEL_SLOW 3'h4
// ****************************************
// Clock rates in kHz
// ****************************************
`define DPT_CORE_KHZ 18'h3_0D40
`define DPT_FAST_KHZ 18'h0_3E80
`define DPT_STEP_W 18
`endif

// file: verilog/dpt_pkg.sv
`default_nettype none
package dpt_pkg;
  typedef logic [7:0] dpt_addr_type;
  typedef logic [31:0] dpt_word_type;
  typedef enum logic [0:0] {PH_HIGH = 1'b0, PH_LOW = 1'b1} dpt_phase_type;
endpackage : dpt_pkg
`default_nettype wire

// file: verilog/dpt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_tick_gen
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_slow_clk, // 32 kHz clock from its pin
  output logic [3:0] o_tick_fast, // 16, 8, 4, 2 MHz ticks
  output logic o_tick_slow // 32 kHz tick
);
  logic [`DPT_STEP_W-1:0] acc_q;
  logic [`DPT_STEP_W:0] acc_sum;
  logic tick16;
  logic [2:0] div_q;
  logic [2:0] slow_sync_q;

  // ****************************************
  // Fractional 16 MHz tick
  // ****************************************
  // The core rate is no integer multiple of 16 MHz, so ticks jitter by one core cycle
  assign acc_sum = {1'b0, acc_q} + {1'b0, `DPT_FAST_KHZ};
  assign tick16 = (acc_sum >= {1'b0, `DPT_CORE_KHZ});

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      acc_q <= '0;
    else if (tick16)
      acc_q <= acc_sum[`DPT_STEP_W-1:0] - `DPT_CORE_KHZ;
    else
      acc_q <= acc_sum[`DPT_STEP_W-1:0];
  end

  // Binary divider for the lower fast rates
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_q <= '0;
    else if (tick16)
      div_q <= div_q + 3'h1;
  end

  assign o_tick_fast[0] = tick16;
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++)
    begin : g_div
      assign o_tick_fast[gi] = tick16 & (&div_q[gi-1:0]);
    end
  endgenerate

  // Slow clock: two flops before the edge detector reads it
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      slow_sync_q <= '0;
    else
      slow_sync_q <= {slow_sync_q[1:0], i_slow_clk};
  end
  assign o_tick_slow = slow_sync_q[1] & ~slow_sync_q[2];
endmodule : dpt_tick_gen
`default_nettype wire

// file: verilog/dpt_timers.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_timers
(
  input wire logic i_core_clk, // 200 MHz core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_slow_clk, // 32 kHz clock pin
  input wire dpt_pkg::dpt_addr_type i_addr, // Register byte address
  input wire dpt_pkg::dpt_word_type i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output dpt_pkg::dpt_word_type o_rdata, // Read data, cycle after strobe
  output logic o_irq, // Level interrupt
  output logic o_first_timer_out_a, // First timer output a
  output logic o_first_timer_out_b, // First timer output b
  output logic o_second_timer_out_a, // Second timer output a
  output logic o_second_timer_out_b, // Second timer output b
  output logic o_second_timer_out_c // Second timer output c
);
  import dpt_pkg::*;

  logic [`DPT_CTRL_W-1:0] ctrl_q;
  logic [15:0] t0_high_q, t0_low_q, t0_reload_q;
  logic [15:0] t0_cnt_q, t0_icnt_q;
  dpt_phase_type t0_phase_q;
  logic [13:0] t2_period_q, t2_per_eff, t2_cnt_q;
  logic [13:0] t2_duty_q [3];
  logic [2:0] t2_pcnt_q, t2_mask;
  logic [2:0] t2_out_q;
  logic [`DPT_IRQ_W-1:0] stat_q, mask_q, events;
  logic [3:0] tick_fast;
  logic tick_slow, t0_en, t0_tick, t2_en, t2_src, t2_tick;
  logic [2:0] t0_sel;
  logic t0_irq_ev, t0_wrap_ev, t2_wrap_ev;
  logic out_a_q, out_b_q, irq_q;
  dpt_word_type rdata_q;

  // ****************************************
  // Clock sources
  // ****************************************
  dpt_tick_gen u_tick_gen
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_slow_clk(i_slow_clk),
    .o_tick_fast(tick_fast),
    .o_tick_slow(tick_slow)
  );

  // Control field decode
  assign t0_en = ctrl_q[`DPT_CTRL_T0_EN];
  assign t0_sel = ctrl_q[`DPT_CTRL_T0_SEL_HI:`DPT_CTRL_T0_SEL_LO];
  assign t2_en = ctrl_q[`DPT_CTRL_T2_EN];
  // Selector codes above the slow code also pick the slow clock
  assign t0_tick = (t0_sel < `DPT_T0_SEL_SLOW) ? tick_fast[t0_sel[1:0]] : tick_slow;
  assign t2_src = ctrl_q[`DPT_CTRL_T2_SLOW] ? tick_slow : tick_fast[0];

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q <= `DPT_RST_CTRL;
      t0_high_q <= `DPT_RST_T0;
      t0_low_q <= `DPT_RST_T0;
      t0_reload_q <= `DPT_RST_T0;
      t2_period_q <= `DPT_RST_T2;
      mask_q <= '0;
      for (int i = 0; i < 3; i++)
        t2_duty_q[i] <= `DPT_RST_T2;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `DPT_OFS_CTRL: ctrl_q <= i_wdata[`DPT_CTRL_W-1:0];
        `DPT_OFS_T0_HIGH: t0_high_q <= i_wdata[15:0];
        `DPT_OFS_T0_LOW: t0_low_q <= i_wdata[15:0];
        `DPT_OFS_T0_RELOAD: t0_reload_q <= i_wdata[15:0];
        `DPT_OFS_T2_PERIOD: t2_period_q <= i_wdata[13:0];
        `DPT_OFS_IRQ_MASK: mask_q <= i_wdata[`DPT_IRQ_W-1:0];
        default:
        begin
          // One duty register per output
          for (int i = 0; i < 3; i++)
            if (i_addr == `DPT_OFS_T2_DUTY0 + 8'(4 * i))
              t2_duty_q[i] <= i_wdata[13:0];
        end
      endcase
    end
  end

  // ****************************************
  // First timer PWM
  // ****************************************
  // Shared 16-bit counter walks the high phase, then the low phase
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      t0_cnt_q <= `DPT_RST_T0;
      t0_phase_q <= PH_HIGH;
    end
    else if (!t0_en)
    begin
      t0_cnt_q <= `DPT_RST_T0;
      t0_phase_q <= PH_HIGH;
    end
    else if (t0_tick)
    begin
      case (t0_phase_q)
        PH_HIGH:
        begin
          // A count shrunk below the counter ends the phase at once
          if (t0_cnt_q >= t0_high_q)
          begin
            t0_cnt_q <= `DPT_RST_T0;
            t0_phase_q <= PH_LOW;
          end
          else
            t0_cnt_q <= t0_cnt_q + 16'h0001;
        end
        PH_LOW:
        begin
          if (t0_cnt_q >= t0_low_q)
          begin
            t0_cnt_q <= `DPT_RST_T0;
            t0_phase_q <= PH_HIGH;
          end
          else
            t0_cnt_q <= t0_cnt_q + 16'h0001;
        end
        default:
        begin
          t0_cnt_q <= `DPT_RST_T0;
          t0_phase_q <= PH_HIGH;
        end
      endcase
    end
  end

  assign t0_wrap_ev = t0_en & t0_tick & (t0_phase_q == PH_LOW) & (t0_cnt_q >= t0_low_q);

  // Both outputs come from the same phase; outputs idle low when disabled
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else
    begin
      out_a_q <= t0_en & (t0_phase_q == PH_HIGH);
      out_b_q <= t0_en & (t0_phase_q == PH_HIGH);
    end
  end

  // Periodic interrupt counter, free of the PWM counts
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      t0_icnt_q <= `DPT_RST_T0;
    else if (!t0_en)
      t0_icnt_q <= t0_reload_q;
    else if (t0_tick)
      t0_icnt_q <= (t0_icnt_q == 16'h0000) ? t0_reload_q : t0_icnt_q - 16'h0001;
  end
  assign t0_irq_ev = t0_en & t0_tick & (t0_icnt_q == 16'h0000);

  // ****************************************
  // Second timer PWM
  // ****************************************
  // Prescaler mask: division by 1, 2, 4 or 8
  always_comb
  begin
    case (ctrl_q[`DPT_CTRL_T2_DIV_HI:`DPT_CTRL_T2_DIV_LO])
      2'h0: t2_mask = 3'h0;
      2'h1: t2_mask = 3'h1;
      2'h2: t2_mask = 3'h3;
      default: t2_mask = 3'h7;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      t2_pcnt_q <= '0;
    else if (!t2_en)
      t2_pcnt_q <= '0;
    else if (t2_src)
      t2_pcnt_q <= t2_pcnt_q + 3'h1;
  end
  assign t2_tick = t2_en & t2_src & ((t2_pcnt_q & t2_mask) == t2_mask);

  // Periods under two are lifted to two, the fastest rate
  assign t2_per_eff = (t2_period_q < `DPT_T2_MIN_PERIOD) ? `DPT_T2_MIN_PERIOD : t2_period_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      t2_cnt_q <= `DPT_RST_T2;
    else if (!t2_en)
      t2_cnt_q <= `DPT_RST_T2;
    else if (t2_tick)
      t2_cnt_q <= (t2_cnt_q >= t2_per_eff - 14'h0001) ? `DPT_RST_T2 : t2_cnt_q + 14'h0001;
  end
  assign t2_wrap_ev = t2_tick & (t2_cnt_q >= t2_per_eff - 14'h0001);

  // Duty zero holds low; duty at or above the period holds high
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_t2_out
      always_ff @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          t2_out_q[gi] <= 1'b0;
        else
          t2_out_q[gi] <= t2_en & ((t2_duty_q[gi] >= t2_per_eff) | (t2_cnt_q < t2_duty_q[gi]));
      end
    end
  endgenerate

  // ****************************************
  // Interrupts and read-back
  // ****************************************
  assign events = {t2_wrap_ev, t0_wrap_ev, t0_irq_ev};

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == `DPT_OFS_IRQ_STAT)
        stat_q <= (stat_q & ~i_wdata[`DPT_IRQ_W-1:0]) | events;
      else
        stat_q <= stat_q | events;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= '0;
    else if (!i_rd)
      rdata_q <= '0;
    else
    begin
      case (i_addr)
        `DPT_OFS_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
        `DPT_OFS_T0_HIGH: rdata_q <= {16'h0000, t0_high_q};
        `DPT_OFS_T0_LOW: rdata_q <= {16'h0000, t0_low_q};
        `DPT_OFS_T0_RELOAD: rdata_q <= {16'h0000, t0_reload_q};
        `DPT_OFS_T2_PERIOD: rdata_q <= {18'h0_0000, t2_period_q};
        `DPT_OFS_IRQ_STAT: rdata_q <= {29'h0000_0000, stat_q};
        `DPT_OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, mask_q};
        `DPT_OFS_STATUS: rdata_q <= {1'b0, t2_cnt_q, t0_phase_q, t0_cnt_q};
        default:
        begin
          rdata_q <= '0;
          for (int i = 0; i < 3; i++)
            if (i_addr == `DPT_OFS_T2_DUTY0 + 8'(4 * i))
              rdata_q <= {18'h0_0000, t2_duty_q[i]};
        end
      endcase
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_first_timer_out_a = out_a_q;
  assign o_first_timer_out_b = out_b_q;
  assign o_second_timer_out_a = t2_out_q[0];
  assign o_second_timer_out_b = t2_out_q[1];
  assign o_second_timer_out_c = t2_out_q[2];

  // ****************************************
  // Assertions
  // ****************************************
  a_t0_outs_match:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n) o_first_timer_out_a == o_first_timer_out_b)
      else $error("first timer outputs differ");
  a_t0_high_end:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t0_en && t0_tick && t0_phase_q == PH_HIGH && t0_cnt_q >= t0_high_q && $stable(ctrl_q))
      |=> t0_phase_q == PH_LOW ##1 !o_first_timer_out_a)
      else $error("high phase did not end");
  a_t0_low_end:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t0_en && t0_tick && t0_phase_q == PH_LOW && t0_cnt_q < t0_low_q && $stable(ctrl_q))
      |=> t0_phase_q == PH_LOW && t0_cnt_q == $past(t0_cnt_q) + 16'h0001)
      else $error("low phase ended early");
  a_t0_irq_reload:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t0_irq_ev && !(i_wr && i_addr == `DPT_OFS_IRQ_STAT))
      |=> stat_q[`DPT_IRQ_T0_TICK] && t0_icnt_q == t0_reload_q)
      else $error("interrupt tick lost or not reloaded");
  a_t2_src_gate:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t2_en && ctrl_q[`DPT_CTRL_T2_SLOW] && !tick_slow) |=> $stable(t2_cnt_q))
      else $error("second timer ticked off its source");
  a_t2_div_one:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t2_en && t2_src && ctrl_q[`DPT_CTRL_T2_DIV_HI:`DPT_CTRL_T2_DIV_LO] == 2'h0) |-> t2_tick)
      else $error("undivided prescaler skipped");
  a_t2_wrap_zero:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t2_wrap_ev && $stable(ctrl_q)) |=> t2_cnt_q == 14'h0000)
      else $error("second timer did not wrap");
  a_t2_duty_low:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t2_duty_q[0] == 14'h0000) |=> !o_second_timer_out_a)
      else $error("zero duty output went high");
  a_t2_duty_high:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (t2_en && t2_duty_q[2] >= t2_per_eff) |=> o_second_timer_out_c)
      else $error("full duty output went low");
endmodule : dpt_timers
`default_nettype wire

// file: verif/test_dual_pwm_timers.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module test_dual_pwm_timers;
  import dpt_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_slow_clk = 1'b0;
  dpt_addr_type i_addr = 8'h00;
  dpt_word_type i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  dpt_word_type o_rdata;
  logic o_irq, t0a, t0b, t2a, t2b, t2c;
  logic [4:0] outs;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi, lo, t1, t2;
  dpt_word_type v;
  assign outs = {t2c, t2b, t2a, t0b, t0a};
  // ****************************************
  // Clocks and design
  // ****************************************
  always #2.5 i_core_clk = ~i_core_clk;
  // Slow pin runs free at 32 kHz, unrelated to the core clock
  always #15625 i_slow_clk = ~i_slow_clk;
  always @(posedge i_core_clk) cyc <= cyc + 1;
  dpt_timers dpt_timers_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_slow_clk(i_slow_clk),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_first_timer_out_a(t0a), .o_first_timer_out_b(t0b), .o_second_timer_out_a(t2a),
    .o_second_timer_out_b(t2b), .o_second_timer_out_c(t2c));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic wr(input dpt_addr_type a, input dpt_word_type d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input dpt_addr_type a, output dpt_word_type d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_rdata;
  endtask : rd
  task automatic chk_word(input string what, input dpt_word_type exp, input dpt_word_type got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // Tick edges jitter by a core cycle or so, hence the tolerance
  task automatic chk_len(input string what, input int exp, input int got, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_len
  task automatic rd_chk(input dpt_addr_type a, input dpt_word_type exp, input string what);
    dpt_word_type d;
    rd(a, d);
    chk_word(what, exp, d);
  endtask : rd_chk
  // Core cycles for n source ticks: 16 MHz is 12.5 cycles, the slow clock 6250
  function automatic int ticks(input int n, input int sh, input bit slow);
    return slow ? n * 6250 * (1 << sh) : n * 25 * (1 << sh) / 2;
  endfunction : ticks
  // One full high then low phase of an output, bounded so a dead output cannot hang
  // The first high phase after enable is cut short by the free-running tick, so skip it
  task automatic meas(input int idx, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (outs[idx] !== 1'b1 && n < 40000) begin @(negedge i_core_clk); n++; end
    while (outs[idx] !== 1'b0 && n < 40000) begin @(negedge i_core_clk); n++; end
    while (outs[idx] !== 1'b1 && n < 40000) begin @(negedge i_core_clk); n++; end
    while (outs[idx] === 1'b1 && n < 40000)
    begin
      @(negedge i_core_clk);
      n++;
      h++;
      if (idx == 0) chk_bit("first timer out b", outs[0], outs[1]);
    end
    while (outs[idx] === 1'b0 && n < 40000) begin @(negedge i_core_clk); n++; l++; end
    chk_bit("output toggling", 1'b1, n < 40000);
  endtask : meas
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (o_irq !== 1'b1 && n < 2000) begin @(negedge i_core_clk); n++; end
    chk_bit("irq raised", 1'b1, o_irq);
    t = cyc;
  endtask : wait_irq
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a <= 'h2C; a += 4) rd_chk(8'(a), 32'h0000_0000, "reset value");
    chk_bit("irq after reset", 1'b0, o_irq);
    for (int a = 4; a <= 'h0C; a += 4) wr(8'(a), 32'hFFFF_FFFF);
    for (int a = 4; a <= 'h0C; a += 4) rd_chk(8'(a), 32'h0000_FFFF, "16 bit count");
    for (int a = 'h10; a <= 'h1C; a += 4) wr(8'(a), 32'hFFFF_FFFF);
    rd_chk(`DPT_OFS_T2_PERIOD, 32'h0000_3FFF, "14 bit period");
    for (int a = 'h14; a <= 'h1C; a += 4) wr(8'(a), 32'(a));
    for (int a = 'h14; a <= 'h1C; a += 4) rd_chk(8'(a), 32'(a), "own duty");
    wr(8'h2C, 32'h1234_5678);
    wr(`DPT_OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk(8'h2C, 32'h0000_0000, "unmapped");
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0000, "status read only");
    @(negedge i_core_clk);
    chk_word("read data after its cycle", 32'h0000_0000, o_rdata);
    $display("test registers done");
    wr(`DPT_OFS_T0_HIGH, 32'h0000_0001);
    wr(`DPT_OFS_T0_LOW, 32'h0000_0002);
    for (int s = 0; s < 4; s++)
    begin
      wr(`DPT_OFS_CTRL, 32'h0000_0000);
      wr(`DPT_OFS_CTRL, 32'(1 + (s << 1)));
      meas(0, hi, lo);
      chk_len("first timer high", ticks(2, s, 0), hi, 2);
      chk_len("first timer low", ticks(3, s, 0), lo, 2);
    end
    wr(`DPT_OFS_T0_HIGH, 32'h0000_0000);
    wr(`DPT_OFS_T0_LOW, 32'h0000_0000);
    wr(`DPT_OFS_CTRL, 32'h0000_0000);
    wr(`DPT_OFS_CTRL, 32'h0000_0009);
    meas(0, hi, lo);
    chk_len("first timer slow high", ticks(1, 0, 1), hi, 4);
    chk_len("first timer slow low", ticks(1, 0, 1), lo, 4);
    $display("test first timer done");
    wr(`DPT_OFS_CTRL, 32'h0000_0000);
    wr(`DPT_OFS_T0_RELOAD, 32'h0000_0003);
    wr(`DPT_OFS_IRQ_STAT, 32'h0000_0007);
    wr(`DPT_OFS_IRQ_MASK, 32'h0000_0001);
    wr(`DPT_OFS_CTRL, 32'h0000_0007);
    wait_irq(t1);
    wr(`DPT_OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(negedge i_core_clk);
    chk_bit("irq after clear", 1'b0, o_irq);
    wait_irq(t2);
    chk_len("tick interval", ticks(4, 3, 0), t2 - t1, 2);
    wr(`DPT_OFS_IRQ_MASK, 32'h0000_0000);
    wr(`DPT_OFS_IRQ_STAT, 32'h0000_0007);
    repeat (500) @(negedge i_core_clk);
    chk_bit("irq masked", 1'b0, o_irq);
    rd(`DPT_OFS_IRQ_STAT, v);
    chk_word("sticky tick and wrap", 32'h0000_0003, v & 32'h0000_0003);
    wr(`DPT_OFS_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(negedge i_core_clk);
    chk_bit("irq unmasked wrap", 1'b1, o_irq);
    wr(`DPT_OFS_CTRL, 32'h0000_0000);
    wr(`DPT_OFS_IRQ_STAT, 32'h0000_0007);
    repeat (3) @(negedge i_core_clk);
    chk_bit("irq cleared", 1'b0, o_irq);
    rd_chk(`DPT_OFS_IRQ_STAT, 32'h0000_0000, "status cleared");
    $display("test interrupt done");
    wr(`DPT_OFS_T2_PERIOD, 32'h0000_0008);
    wr(`DPT_OFS_T2_DUTY0, 32'h0000_0000);
    wr(8'h18, 32'h0000_0003);
    wr(8'h1C, 32'h0000_0008);
    for (int d = 0; d < 4; d++)
    begin
      wr(`DPT_OFS_CTRL, 32'h0000_0000);
      wr(`DPT_OFS_CTRL, 32'(8'h10 + (d << 6)));
      meas(3, hi, lo);
      chk_len("second timer b high", ticks(3, d, 0), hi, 2);
      chk_len("second timer b low", ticks(5, d, 0), lo, 2);
      chk_bit("second timer a low", 1'b0, t2a);
      chk_bit("second timer c high", 1'b1, t2c);
    end
    wr(`DPT_OFS_T2_PERIOD, 32'h0000_0002);
    wr(`DPT_OFS_T2_DUTY0, 32'h0000_0001);
    wr(`DPT_OFS_CTRL, 32'h0000_0000);
    wr(`DPT_OFS_CTRL, 32'h0000_00D0);
    meas(2, hi, lo);
    chk_len("shortest period high", ticks(1, 3, 0), hi, 2);
    chk_len("shortest period low", ticks(1, 3, 0), lo, 2);
    wr(`DPT_OFS_CTRL, 32'h0000_0000);
    wr(`DPT_OFS_CTRL, 32'h0000_0030);
    meas(2, hi, lo);
    chk_len("slow system clock high", ticks(1, 0, 1), hi, 4);
    chk_len("slow system clock low", ticks(1, 0, 1), lo, 4);
    $display("test second timer done");
    finish_test();
  end
  // Whole run needs under 60000 cycles, most of it in the two slow clock tests
  initial
  begin
    repeat (90000) @(posedge i_core_clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen running");
    finish_test();
  end
endmodule : test_dual_pwm_timers
`default_nettype wire
